// >>> shared/oid_pkg.sv
// Shared constants for the ID pin detection block and its link controller
`default_nettype none

package oid_pkg;

    // ------------------------
    // Clock and timing
    // ------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int BIAS_SETTLE_MS = 50;
    localparam int BIAS_SETTLE_CYCLES = BIAS_SETTLE_MS * (CLK_HZ / 1000);
    localparam int RID_CONV_US = 1;
    localparam int RID_CONV_CYCLES = RID_CONV_US * (CLK_HZ / 1_000_000);

    // ------------------------
    // Register addresses
    // ------------------------
    localparam logic [5:0] ADDR_OTG_CTRL = 6'h0a;
    localparam logic [5:0] ADDR_IRQ_RISE = 6'h0d;
    localparam logic [5:0] ADDR_IRQ_FALL = 6'h10;
    localparam logic [5:0] ADDR_IRQ_STAT = 6'h13;
    localparam logic [5:0] ADDR_CARKIT_STAT = 6'h19;
    localparam logic [5:0] ADDR_RID_CTRL = 6'h30;

    // ------------------------
    // Field positions
    // ------------------------
    localparam int BIAS_EN_BIT = 0;
    localparam int GND_BIT = 4;
    localparam int OPEN_EN_BIT = 5;
    localparam int OPEN_STAT_BIT = 0;
    localparam int RID_START_BIT = 0;
    localparam int RID_DONE_BIT = 1;
    localparam int RID_CODE_LSB = 2;
    localparam int RX_ID_BIT = 6;
    localparam int RX_ALT_BIT = 7;

    // ------------------------
    // Reset values and resistance codes
    // ------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RID_GROUND = 3'h0;
    localparam logic [2:0] RID_75R = 3'h1;
    localparam logic [2:0] RID_102K = 3'h2;
    localparam logic [2:0] RID_200K = 3'h3;
    localparam logic [2:0] RID_440K = 3'h4;
    localparam logic [2:0] RID_FLOAT = 3'h5;

endpackage

`default_nettype wire

// >>> shared/oid_link_if.sv
// Register access and receive-command carrier between phy end and link end
`default_nettype none

interface oid_link_if;
    logic reg_req;
    logic reg_we;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic rxcmd_valid;
    logic [7:0] rxcmd_data;

    modport phy (
        input reg_req,
        input reg_we,
        input reg_addr,
        input reg_wdata,
        output reg_ack,
        output reg_rdata,
        output rxcmd_valid,
        output rxcmd_data
    );

    modport link (
        output reg_req,
        output reg_we,
        output reg_addr,
        output reg_wdata,
        input reg_ack,
        input reg_rdata,
        input rxcmd_valid,
        input rxcmd_data
    );
endinterface

`default_nettype wire

// >>> verilog/oid_phy.sv
// Device end: ID pin comparator readout, bias control, resistance converter
//
// Summary of operation
// - Grounded ID means A plug, open means B
// - Link enables bias, waits 50 ms, reads flag
// - Weak bias holds ID high when idle
// - Largest resistor pulls grounded comparator low, interrupting
// - Converter codes ground to floating, bias off
// - Converter runs synchronously after grounded flag falls
// - Bias enable bit connects strong 100K pull-up
// - Open changes send alternate-interrupt receive command
// - Flags 1/1 float, 1/0 102K, 0/0 ground
// - Link clears bias and open enables on A
// - Weak bias returns ID high after removal
// - Grounded flag at bit 4 of status
// - Grounded flag changes interrupt when edges enabled
// - Open flag at bit 0 of carkit status
// - Link prefers converter over open comparator
`default_nettype none

module oid_phy #(
    parameter int CONV_CYCLES = oid_pkg::RID_CONV_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link side
    oid_link_if.phy link,
    // Analog comparators and converter
    input wire logic id_gnd_cmp,
    input wire logic id_open_cmp,
    input wire logic [2:0] rid_code_in,
    // Analog controls and cable state
    output logic strong_bias_on,
    output logic weak_id_bias,
    output logic rid_conv_en,
    output logic a_plug
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic gnd_s1;
        logic gnd_s2;
        logic id_grounded_flag;
        logic open_s1;
        logic open_s2;
        logic open_level;
        logic [2:0] rid_s1;
        logic [2:0] rid_s2;
        logic id_bias_enable;
        logic gnd_rise_en;
        logic gnd_fall_en;
        logic id_open_rise_irq_en;
        logic id_open_fall_irq_en;
        logic conv_busy;
        logic conv_done;
        logic [15:0] conv_cnt;
        logic [2:0] rid_code;
        logic gnd_pend;
        logic open_pend;
        logic ack;
        logic [7:0] rdata;
        logic rx_valid;
        logic [7:0] rx_data;
        logic strong_bias;
        logic weak_bias;
        logic a_plug;
    } oid_phy_state_t;

    oid_phy_state_t st;
    oid_phy_state_t next_st;

    logic id_open_flag;
    logic gnd_rise;
    logic gnd_fall;
    logic open_rise;
    logic open_fall;
    logic acc;

    // Open comparator is only powered with the strong bias on
    assign id_open_flag = st.open_level & st.id_bias_enable;
    assign gnd_rise = st.gnd_s2 & ~st.id_grounded_flag;
    assign gnd_fall = ~st.gnd_s2 & st.id_grounded_flag;
    assign open_rise = st.open_s2 & ~st.open_level;
    assign open_fall = ~st.open_s2 & st.open_level;
    // Access taken once per request; ack drops the cycle after
    assign acc = link.reg_req & ~st.ack;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Two-stage synchronisers, first stage read only by the second
        next_st.gnd_s1 = id_gnd_cmp;
        next_st.gnd_s2 = st.gnd_s1;
        next_st.open_s1 = id_open_cmp;
        next_st.open_s2 = st.open_s1;
        next_st.rid_s1 = rid_code_in;
        next_st.rid_s2 = st.rid_s1;

        // Flags follow the synchronised comparators
        next_st.id_grounded_flag = st.gnd_s2;
        next_st.open_level = st.open_s2;
        next_st.a_plug = ~st.gnd_s2;

        // Weak bias is never switched off; it keeps a bare pin high
        next_st.weak_bias = 1'b1;
        next_st.strong_bias = st.id_bias_enable;

        // Register access
        next_st.ack = acc;
        next_st.rdata = oid_pkg::RST_BYTE;
        if (acc && link.reg_we) begin
            case (link.reg_addr)
                oid_pkg::ADDR_OTG_CTRL: begin
                    next_st.id_bias_enable = link.reg_wdata[oid_pkg::BIAS_EN_BIT];
                end
                oid_pkg::ADDR_IRQ_RISE: begin
                    next_st.gnd_rise_en = link.reg_wdata[oid_pkg::GND_BIT];
                    next_st.id_open_rise_irq_en = link.reg_wdata[oid_pkg::OPEN_EN_BIT];
                end
                oid_pkg::ADDR_IRQ_FALL: begin
                    next_st.gnd_fall_en = link.reg_wdata[oid_pkg::GND_BIT];
                    next_st.id_open_fall_irq_en = link.reg_wdata[oid_pkg::OPEN_EN_BIT];
                end
                oid_pkg::ADDR_RID_CTRL: begin
                    // Start refused while strong bias would skew the reading
                    if (link.reg_wdata[oid_pkg::RID_START_BIT] && !st.id_bias_enable
                        && !st.conv_busy) begin
                        next_st.conv_busy = 1'b1;
                        next_st.conv_done = 1'b0;
                        next_st.conv_cnt = 16'h0000;
                    end
                end
                default: begin
                end
            endcase
        end else if (acc) begin
            case (link.reg_addr)
                oid_pkg::ADDR_OTG_CTRL: begin
                    next_st.rdata[oid_pkg::BIAS_EN_BIT] = st.id_bias_enable;
                end
                oid_pkg::ADDR_IRQ_RISE: begin
                    next_st.rdata[oid_pkg::GND_BIT] = st.gnd_rise_en;
                    next_st.rdata[oid_pkg::OPEN_EN_BIT] = st.id_open_rise_irq_en;
                end
                oid_pkg::ADDR_IRQ_FALL: begin
                    next_st.rdata[oid_pkg::GND_BIT] = st.gnd_fall_en;
                    next_st.rdata[oid_pkg::OPEN_EN_BIT] = st.id_open_fall_irq_en;
                end
                oid_pkg::ADDR_IRQ_STAT: begin
                    next_st.rdata[oid_pkg::GND_BIT] = st.id_grounded_flag;
                end
                oid_pkg::ADDR_CARKIT_STAT: begin
                    next_st.rdata[oid_pkg::OPEN_STAT_BIT] = id_open_flag;
                end
                oid_pkg::ADDR_RID_CTRL: begin
                    next_st.rdata[oid_pkg::RID_START_BIT] = st.conv_busy;
                    next_st.rdata[oid_pkg::RID_DONE_BIT] = st.conv_done;
                    next_st.rdata[oid_pkg::RID_CODE_LSB +: 3] = st.rid_code;
                end
                default: begin
                end
            endcase
        end

        // Converter: settle for the conversion time, then capture
        if (st.conv_busy) begin
            if (st.conv_cnt == 16'(CONV_CYCLES - 1)) begin
                next_st.conv_busy = 1'b0;
                next_st.conv_done = 1'b1;
                next_st.rid_code = st.rid_s2;
            end else begin
                next_st.conv_cnt = st.conv_cnt + 16'h0001;
            end
        end

        // Pending notifications; a new edge wins over the clear that follows the send
        next_st.rx_valid = 1'b0;
        next_st.rx_data = oid_pkg::RST_BYTE;
        if (st.gnd_pend) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data[oid_pkg::RX_ID_BIT] = st.id_grounded_flag;
            next_st.gnd_pend = 1'b0;
        end else if (st.open_pend) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data[oid_pkg::RX_ID_BIT] = st.id_grounded_flag;
            next_st.rx_data[oid_pkg::RX_ALT_BIT] = 1'b1;
            next_st.open_pend = 1'b0;
        end
        if ((gnd_rise && st.gnd_rise_en) || (gnd_fall && st.gnd_fall_en)) begin
            next_st.gnd_pend = 1'b1;
        end
        if (st.id_bias_enable && ((open_rise && st.id_open_rise_irq_en)
            || (open_fall && st.id_open_fall_irq_en))) begin
            next_st.open_pend = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
            st.gnd_s1 <= 1'b1;
            st.gnd_s2 <= 1'b1;
            st.id_grounded_flag <= 1'b1;
            st.weak_bias <= 1'b1;
            st.rid_code <= oid_pkg::RID_FLOAT;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------
    assign link.reg_ack = st.ack;
    assign link.reg_rdata = st.rdata;
    assign link.rxcmd_valid = st.rx_valid;
    assign link.rxcmd_data = st.rx_data;
    assign strong_bias_on = st.strong_bias;
    assign weak_id_bias = st.weak_bias;
    assign rid_conv_en = st.conv_busy;
    assign a_plug = st.a_plug;

endmodule

`default_nettype wire

// >>> verilog/oid_link.sv
// Link end: cable detection sequence and resistance readout over the carrier
`default_nettype none

module oid_link #(
    parameter int SETTLE_CYCLES = oid_pkg::BIAS_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Phy side
    oid_link_if.link phy,
    // User side
    input wire logic detect_start,
    output logic detect_busy,
    output logic cable_valid,
    output logic cable_is_a,
    output logic rid_valid,
    output logic [2:0] rid_value,
    output logic open_change
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_BIAS_ON = 10'h002,
        S_SETTLE = 10'h004,
        S_RD_STAT = 10'h008,
        S_BIAS_OFF = 10'h010,
        S_WR_RISE = 10'h020,
        S_WR_FALL = 10'h040,
        S_MONITOR = 10'h080,
        S_WR_RID = 10'h100,
        S_RD_RID = 10'h200
    } oid_link_fsm_t;

    typedef struct packed {
        oid_link_fsm_t fsm;
        logic [23:0] cnt;
        logic req;
        logic we;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic busy;
        logic cable_valid;
        logic cable_is_a;
        logic rid_valid;
        logic [2:0] rid_value;
        logic open_change;
    } oid_link_state_t;

    oid_link_state_t st;
    oid_link_state_t next_st;

    // ------------------------------------------------------------------
    // Sequencer; every bus state raises req once and waits for ack, except S_RD_RID, which repeats its read until the done bit is set
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.open_change = 1'b0;
        if (phy.reg_ack) begin
            next_st.req = 1'b0;
        end
        case (st.fsm)
            S_IDLE: begin
                if (detect_start) begin
                    next_st.busy = 1'b1;
                    next_st.cable_valid = 1'b0;
                    next_st.fsm = S_BIAS_ON;
                end
            end
            S_BIAS_ON: begin
                if (!st.req && !phy.reg_ack) begin
                    next_st.req = 1'b1;
                    next_st.we = 1'b1;
                    next_st.addr = oid_pkg::ADDR_OTG_CTRL;
                    next_st.wdata = 8'h00;
                    next_st.wdata[oid_pkg::BIAS_EN_BIT] = 1'b1;
                end else if (phy.reg_ack) begin
                    next_st.cnt = 24'h000000;
                    next_st.fsm = S_SETTLE;
                end
            end
            S_SETTLE: begin
                // Pin needs the full settle time before the flag is trusted
                if (st.cnt == 24'(SETTLE_CYCLES - 1)) begin
                    next_st.fsm = S_RD_STAT;
                end else begin
                    next_st.cnt = st.cnt + 24'h000001;
                end
            end
            S_RD_STAT: begin
                if (!st.req && !phy.reg_ack) begin
                    next_st.req = 1'b1;
                    next_st.we = 1'b0;
                    next_st.addr = oid_pkg::ADDR_IRQ_STAT;
                end else if (phy.reg_ack) begin
                    next_st.cable_is_a = ~phy.reg_rdata[oid_pkg::GND_BIT];
                    next_st.cable_valid = 1'b1;
                    next_st.fsm = S_BIAS_OFF;
                end
            end
            S_BIAS_OFF: begin
                if (!st.req && !phy.reg_ack) begin
                    next_st.req = 1'b1;
                    next_st.we = 1'b1;
                    next_st.addr = oid_pkg::ADDR_OTG_CTRL;
                    next_st.wdata = 8'h00;
                end else if (phy.reg_ack) begin
                    next_st.fsm = S_WR_RISE;
                end
            end
            S_WR_RISE, S_WR_FALL: begin
                // Open enables stay clear: the converter is the better tool
                if (!st.req && !phy.reg_ack) begin
                    next_st.req = 1'b1;
                    next_st.we = 1'b1;
                    next_st.addr = (st.fsm == S_WR_RISE) ? oid_pkg::ADDR_IRQ_RISE
                                                         : oid_pkg::ADDR_IRQ_FALL;
                    next_st.wdata = 8'h00;
                    next_st.wdata[oid_pkg::GND_BIT] = 1'b1;
                end else if (phy.reg_ack) begin
                    next_st.fsm = (st.fsm == S_WR_RISE) ? S_WR_FALL : S_MONITOR;
                    next_st.busy = (st.fsm == S_WR_RISE);
                end
            end
            S_MONITOR: begin
                if (detect_start) begin
                    next_st.busy = 1'b1;
                    next_st.cable_valid = 1'b0;
                    next_st.fsm = S_BIAS_ON;
                end else if (phy.rxcmd_valid && phy.rxcmd_data[oid_pkg::RX_ALT_BIT]) begin
                    next_st.open_change = 1'b1;
                end else if (phy.rxcmd_valid) begin
                    next_st.cable_is_a = ~phy.rxcmd_data[oid_pkg::RX_ID_BIT];
                    if (!phy.rxcmd_data[oid_pkg::RX_ID_BIT]) begin
                        next_st.busy = 1'b1;
                        next_st.rid_valid = 1'b0;
                        next_st.fsm = S_WR_RID;
                    end
                end
            end
            S_WR_RID: begin
                if (!st.req && !phy.reg_ack) begin
                    next_st.req = 1'b1;
                    next_st.we = 1'b1;
                    next_st.addr = oid_pkg::ADDR_RID_CTRL;
                    next_st.wdata = 8'h00;
                    next_st.wdata[oid_pkg::RID_START_BIT] = 1'b1;
                end else if (phy.reg_ack) begin
                    next_st.fsm = S_RD_RID;
                end
            end
            S_RD_RID: begin
                if (!st.req && !phy.reg_ack) begin
                    next_st.req = 1'b1;
                    next_st.we = 1'b0;
                    next_st.addr = oid_pkg::ADDR_RID_CTRL;
                end else if (phy.reg_ack && phy.reg_rdata[oid_pkg::RID_DONE_BIT]) begin
                    next_st.rid_value = phy.reg_rdata[oid_pkg::RID_CODE_LSB +: 3];
                    next_st.rid_valid = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.fsm = S_MONITOR;
                end
            end
            default: begin
                next_st.fsm = S_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
            st.fsm <= S_IDLE;
            st.rid_value <= oid_pkg::RID_FLOAT;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------
    assign phy.reg_req = st.req;
    assign phy.reg_we = st.we;
    assign phy.reg_addr = st.addr;
    assign phy.reg_wdata = st.wdata;
    assign detect_busy = st.busy;
    assign cable_valid = st.cable_valid;
    assign cable_is_a = st.cable_is_a;
    assign rid_valid = st.rid_valid;
    assign rid_value = st.rid_value;
    assign open_change = st.open_change;

endmodule

`default_nettype wire

// >>> tb/oid_monitor.sv
// Checker for register traffic and notifications on the carrier
`default_nettype none

module oid_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register access
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [7:0] reg_rdata,
    // Notifications
    input wire logic rxcmd_valid,
    input wire logic [7:0] rxcmd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic bias_on;
    logic rid_started;
    logic gnd_last;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ------------------------
    // Shadow state
    // ------------------------
    // Shadows lag the phy a cycle; accesses are three cycles apart
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bias_on <= 1'b0;
            rid_started <= 1'b0;
            gnd_last <= 1'b1; // Flag resets high, first edge is a fall
        end else begin
            if (reg_req && reg_ack && reg_we && reg_addr == oid_pkg::ADDR_OTG_CTRL) begin
                bias_on <= reg_wdata[oid_pkg::BIAS_EN_BIT];
            end
            if (reg_req && reg_ack && reg_we && reg_addr == oid_pkg::ADDR_RID_CTRL &&
                reg_wdata[oid_pkg::RID_START_BIT] && !bias_on) begin
                rid_started <= 1'b1;
            end
            if (rxcmd_valid && !rxcmd_data[oid_pkg::RX_ALT_BIT]) begin
                gnd_last <= rxcmd_data[oid_pkg::RX_ID_BIT];
            end
        end
    end

    // ------------------------
    // Properties
    // ------------------------
    sequence rid_read;
        reg_req && !reg_we && reg_addr == oid_pkg::ADDR_RID_CTRL && !reg_ack ##1 reg_ack;
    endsequence

    a_ack_follows_req: assert property (
        reg_req && !reg_ack |=> reg_ack) else $error("ack late");
    a_ack_single: assert property (
        reg_ack |=> !reg_ack) else $error("ack too long");
    a_ack_has_req: assert property (
        reg_ack |-> $past(reg_req)) else $error("stray ack");
    a_rdata_idle_zero: assert property (
        !reg_ack |-> reg_rdata == 8'h00) else $error("stray read data");
    a_write_rdata_zero: assert property (
        reg_ack && reg_we |-> reg_rdata == 8'h00) else $error("read data on write");
    a_rx_spare_zero: assert property (
        rxcmd_valid |-> rxcmd_data[5:0] == 6'h00) else $error("spare bits set");
    a_rid_code_range: assert property (
        rid_read |-> !reg_rdata[oid_pkg::RID_DONE_BIT] ||
            reg_rdata[oid_pkg::RID_CODE_LSB +: 3] <= 3'h5) else $error("code out of range");
    a_rid_started_seen: assert property (
        rid_read |-> !rid_started || reg_rdata[1:0] != 2'h0) else $error("start lost");
    a_gnd_alternates: assert property (
        rxcmd_valid && !rxcmd_data[oid_pkg::RX_ALT_BIT]
            |-> rxcmd_data[oid_pkg::RX_ID_BIT] != gnd_last) else $error("repeated flag edge");
endmodule

`default_nettype wire

// >>> tb/otg_id_pin_detection_tb.sv
// Bench: both ends joined, plus a second phy driven by tasks
`default_nettype none

module otg_id_pin_detection_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, reset, detect_start, gnd_cmp, open_cmp;
    logic [2:0] rid_code, rval;
    logic a_strong, a_weak, a_plug, busy, cvalid, is_a, rvalid, b_strong;
    logic [7:0] q;
    int n_errors, check_count, cycles, n_alt, n_grx, a0, g0, n, c, i;

    oid_link_if bus_a();
    oid_link_if bus_b();

    // ------------------------
    // Design under test
    // ------------------------
    oid_phy #(.CONV_CYCLES(4)) u_oid_phy (.sys_clk(sys_clk), .reset(reset), .link(bus_a),
        .id_gnd_cmp(gnd_cmp), .id_open_cmp(open_cmp), .rid_code_in(rid_code),
        .strong_bias_on(a_strong), .weak_id_bias(a_weak), .rid_conv_en(), .a_plug(a_plug));
    oid_link #(.SETTLE_CYCLES(20)) u_oid_link (.sys_clk(sys_clk), .reset(reset), .phy(bus_a),
        .detect_start(detect_start), .detect_busy(busy), .cable_valid(cvalid),
        .cable_is_a(is_a), .rid_valid(rvalid), .rid_value(rval), .open_change());
    // Second phy on the same pins, driven by bench tasks
    oid_phy #(.CONV_CYCLES(4)) u_oid_phy_b (.sys_clk(sys_clk), .reset(reset), .link(bus_b),
        .id_gnd_cmp(gnd_cmp), .id_open_cmp(open_cmp), .rid_code_in(rid_code),
        .strong_bias_on(b_strong), .weak_id_bias(), .rid_conv_en(), .a_plug());
    oid_monitor u_oid_monitor (.sys_clk(sys_clk), .reset(reset), .reg_req(bus_a.reg_req),
        .reg_we(bus_a.reg_we), .reg_addr(bus_a.reg_addr), .reg_wdata(bus_a.reg_wdata),
        .reg_ack(bus_a.reg_ack), .reg_rdata(bus_a.reg_rdata),
        .rxcmd_valid(bus_a.rxcmd_valid), .rxcmd_data(bus_a.rxcmd_data));

    // ------------------------
    // Clock, watchdog, notification counters
    // ------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Run is a few hundred cycles; ceiling catches a hang
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
        if (bus_b.rxcmd_valid === 1'b1) begin
            if (bus_b.rxcmd_data[oid_pkg::RX_ALT_BIT] === 1'b1) n_alt++;
            else n_grx++;
        end
    end

    // ------------------------
    // Tasks
    // ------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until ack is seen, released the edge after
    task automatic acc(input logic we, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        int k;
        @(posedge sys_clk);
        bus_b.reg_req <= 1'b1;
        bus_b.reg_we <= we;
        bus_b.reg_addr <= a;
        bus_b.reg_wdata <= d;
        for (k = 0; k < 10; k++) begin
            @(posedge sys_clk);
            #1;
            if (bus_b.reg_ack === 1'b1) break;
        end
        r = bus_b.reg_rdata;
        if (k == 10) n_errors++;
        @(posedge sys_clk);
        bus_b.reg_req <= 1'b0;
    endtask

    task automatic detect();
        int k;
        @(posedge sys_clk);
        detect_start <= 1'b1;
        @(posedge sys_clk);
        detect_start <= 1'b0;
        for (k = 0; k < 10 && busy !== 1'b1; k++) @(posedge sys_clk);
        for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge sys_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        reset = 1'b1;
        detect_start = 1'b0;
        gnd_cmp = 1'b1;
        open_cmp = 1'b1;
        rid_code = 3'h0;
        bus_b.reg_req = 1'b0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({5'h00, rval}, 8'h05);
        // Floating pin, then a grounded cable with a resistor
        detect();
        chk({6'h00, cvalid, is_a}, 8'h02);
        chk({6'h00, a_weak, a_strong}, 8'h02);
        rid_code <= 3'h2;
        gnd_cmp <= 1'b0;
        open_cmp <= 1'b0;
        for (n = 0; n < 200 && rvalid !== 1'b1; n++) @(posedge sys_clk);
        #1;
        chk({5'h00, rval}, 8'h02);
        chk({7'h00, a_plug}, 8'h01);
        detect();
        chk({6'h00, cvalid, is_a}, 8'h03);
        gnd_cmp <= 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        chk({7'h00, a_plug}, 8'h00);
        // Reset value, unmapped place, bias write
        acc(1'b0, oid_pkg::ADDR_OTG_CTRL, 8'h00, q);
        chk(q, oid_pkg::RST_BYTE);
        acc(1'b1, 6'h3f, 8'hff, q);
        acc(1'b0, 6'h3f, 8'h00, q);
        chk(q, 8'h00);
        acc(1'b1, oid_pkg::ADDR_OTG_CTRL, 8'h01, q);
        acc(1'b0, oid_pkg::ADDR_OTG_CTRL, 8'h00, q);
        chk({q[7:1], b_strong}, 8'h01);
        // Flag pairs for floating, 102K and grounded pin
        for (i = 0; i < 3; i++) begin
            gnd_cmp <= (i != 2);
            open_cmp <= (i == 0);
            repeat (4) @(posedge sys_clk);
            acc(1'b0, oid_pkg::ADDR_IRQ_STAT, 8'h00, q);
            chk(q & 8'h10, (i != 2) ? 8'h10 : 8'h00);
            acc(1'b0, oid_pkg::ADDR_CARKIT_STAT, 8'h00, q);
            chk(q & 8'h01, (i == 0) ? 8'h01 : 8'h00);
        end
        // Edge notifications, last two with both flags moving
        acc(1'b1, oid_pkg::ADDR_IRQ_RISE, 8'h30, q);
        acc(1'b1, oid_pkg::ADDR_IRQ_FALL, 8'h30, q);
        a0 = n_alt;
        g0 = n_grx;
        for (i = 0; i < 4; i++) begin
            gnd_cmp <= (i != 2);
            open_cmp <= i[0];
            repeat (8) @(posedge sys_clk);
        end
        chk(8'(n_alt - a0), 8'h03);
        chk(8'(n_grx - g0), 8'h03);
        // Converter codes, then a start refused with bias on
        acc(1'b1, oid_pkg::ADDR_OTG_CTRL, 8'h00, q);
        for (c = 0; c < 6; c++) begin
            rid_code <= c[2:0];
            repeat (4) @(posedge sys_clk);
            acc(1'b1, oid_pkg::ADDR_RID_CTRL, 8'h01, q);
            for (n = 0; n < 20; n++) begin
                acc(1'b0, oid_pkg::ADDR_RID_CTRL, 8'h00, q);
                if (q[oid_pkg::RID_DONE_BIT] === 1'b1) break;
            end
            chk({5'h00, q[4:2]}, 8'(c));
        end
        acc(1'b1, oid_pkg::ADDR_OTG_CTRL, 8'h01, q);
        acc(1'b1, oid_pkg::ADDR_RID_CTRL, 8'h01, q);
        acc(1'b0, oid_pkg::ADDR_RID_CTRL, 8'h00, q);
        chk(q & 8'h01, 8'h00);
        tally_and_finish();
    end
endmodule

`default_nettype wire
